// ### pkg/nvm_pkg.sv
// Constants, types and the contract summary for the nonvolatile access block
// Contract
// RQ1: Provide 64 bytes data SRAM, 64 bytes data EEPROM, 1K bytes code EEPROM.
// RQ2: Program may read and write SRAM and data EEPROM, only read code EEPROM.
// RQ3: In normal mode every write aimed at code EEPROM is blocked.
// RQ4: Code EEPROM rewritable only in program mode with code write lock clear.
// RQ5: Software polls the ready flag before issuing a data EEPROM write.
// RQ6: Ready flag reads 1 when a write may start, 0 while writing.
// RQ7: Ready flag returns high when the data EEPROM write cycle completes.
// RQ8: Software avoids EEPROM access and halt or idle while ready shows busy.
// RQ9: At power-up the two initialization bytes are fetched and configure peripherals.
// RQ10: Second initialization byte supplies the oscillator trim, factory value gives 1MHz.
// RQ11: Both initialization bytes are readable and writable only in programming mode.
// RQ12: Programmer should not rewrite the oscillator trim after leaving the factory.
// RQ13: Readout lock refuses memory reads in programming mode and can never clear.
// RQ14: Boot byte bit 3 enables the low-supply detection circuit.
// RQ15: Boot byte bit 4 permits brown-out reset below the reference level.
// RQ16: Boot byte bit 5 enables the processor watchdog circuit.
// RQ17: Clock select bit 1 comes from bit 6, select bit 0 from bit 7.
// RQ18: Boot byte bit 2 blocks writes to data EEPROM 0x60 through 0x7F.
// RQ19: Initialization bytes sit at data addresses 0xBB and 0xBC.
// RQ20: SRAM at data 0x00-0x3F, data EEPROM at data 0x40-0x7F.
package nvm_pkg;
    // Array sizes and index widths
    localparam int SRAM_BYTES = 64;
    localparam int DEE_BYTES = 64;
    localparam int CODE_BYTES = 1024;
    localparam int DATA_AW = 6;
    localparam int CODE_AW = 10;
    // Data space map
    localparam logic [7:0] SRAM_LAST = 8'h3f;
    localparam logic [7:0] DEE_BASE = 8'h40;
    localparam logic [7:0] DEE_LAST = 8'h7f;
    localparam logic [7:0] DEE_UPPER_BASE = 8'h60;
    localparam logic [7:0] BOOT_CFG_ADDR = 8'hbb;
    localparam logic [7:0] OSC_TRIM_ADDR = 8'hbc;
    localparam logic [7:0] FLAGS_ADDR = 8'hcf;
    // Boot configuration byte fields
    localparam int READOUT_LOCK_BIT = 0;
    localparam int CODE_WRITE_LOCK_BIT = 1;
    localparam int UPPER_LOCK_BIT = 2;
    localparam int LOW_SUPPLY_BIT = 3;
    localparam int BROWNOUT_BIT = 4;
    localparam int WATCHDOG_BIT = 5;
    localparam int CLK_SEL1_BIT = 6;
    localparam int CLK_SEL0_BIT = 7;
    localparam logic [7:0] READOUT_LOCK_MASK = 8'h01;
    // Core flags register field
    localparam int READY_BIT = 0;
    // Power-up contents of the stored initialization bytes (arbitrary trim value)
    localparam logic [7:0] BOOT_CFG_DEFAULT = 8'h00;
    localparam logic [7:0] OSC_TRIM_DEFAULT = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int EE_WRITE_TIME_US = 2500;
    localparam int TIMER_W = 20;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 20'h00000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h00001;
    // Power-up fetch sequence
    typedef enum logic [1:0] {BOOT_FETCH_CFG, BOOT_FETCH_TRIM, BOOT_RUN} boot_state_t;
endpackage : nvm_pkg

// ### pkg/mem_port_if.sv
// Byte-wide memory port between the access controller and its arrays
interface mem_port_if #(parameter int AW = 6);
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport owner (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface : mem_port_if

// ### rtl/byte_array.sv
// Byte array used for SRAM, data EEPROM and code EEPROM storage
module byte_array #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic core_clk,
    // Access port
    mem_port_if.store port
);
    logic [7:0] mem [DEPTH];

    // Write on strobe; contents are not reset, like real storage
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
    end

    // Asynchronous read, registered by the controller
    assign port.rdata = mem[port.addr];
endmodule : byte_array

// ### rtl/ee_write_timer.sv
// Data EEPROM write cycle timer producing the busy indication
module ee_write_timer #(
    parameter logic [19:0] CYCLES = 20'd125000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic busy
);
    logic [19:0] remaining;

    // Load on start, count down to zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            remaining <= nvm_pkg::TIMER_ZERO;
        end else if (start && remaining == nvm_pkg::TIMER_ZERO) begin
            remaining <= CYCLES;
        end else if (remaining != nvm_pkg::TIMER_ZERO) begin
            remaining <= remaining - nvm_pkg::TIMER_ONE;
        end
    end

    assign busy = remaining != nvm_pkg::TIMER_ZERO;
endmodule : ee_write_timer

// ### rtl/nvm_access_top.sv
// Memory access control, write protection and boot configuration for the core
module nvm_access_top #(
    parameter int EE_WRITE_CYCLES = nvm_pkg::EE_WRITE_TIME_US * nvm_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Operating mode
    input wire logic program_mode,
    // Data space register port
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // Program space port
    input wire logic [9:0] code_addr,
    input wire logic [7:0] code_wdata,
    input wire logic code_wr,
    input wire logic code_rd,
    output logic [7:0] code_rdata,
    // Peripheral configuration outputs
    output logic low_supply_detect_enable,
    output logic brownout_reset_enable,
    output logic watchdog_circuit_enable,
    output logic [1:0] clock_source_select,
    output logic [7:0] osc_trim,
    // Status
    output logic ee_ready,
    output logic boot_done
);
    nvm_pkg::boot_state_t boot_state;
    nvm_pkg::boot_state_t next_boot_state;

    // Stored initialization bytes and their copies taken at power-up
    logic [7:0] stored_cfg = nvm_pkg::BOOT_CFG_DEFAULT; // Blank part at time zero
    logic [7:0] stored_trim = nvm_pkg::OSC_TRIM_DEFAULT; // RQ10
    logic [7:0] active_cfg;
    logic [7:0] active_trim;

    // Address decode
    logic in_sram;
    logic in_dee;
    logic in_dee_upper;
    logic hit_boot_cfg;
    logic hit_osc_trim;
    logic hit_flags;

    // Access qualifiers
    logic booted;
    logic read_locked;
    logic ee_busy;
    logic sram_write;
    logic dee_write;
    logic code_write;
    logic init_access;

    // Storage ports
    mem_port_if #(.AW(nvm_pkg::DATA_AW)) sram_port ();
    mem_port_if #(.AW(nvm_pkg::DATA_AW)) dee_port ();
    mem_port_if #(.AW(nvm_pkg::CODE_AW)) code_port ();

    // Data space decode of the fixed memory map
    assign in_sram = bus_addr <= nvm_pkg::SRAM_LAST; // RQ20
    assign in_dee = bus_addr >= nvm_pkg::DEE_BASE && bus_addr <= nvm_pkg::DEE_LAST; // RQ20
    assign in_dee_upper = in_dee && bus_addr >= nvm_pkg::DEE_UPPER_BASE;
    assign hit_boot_cfg = bus_addr == nvm_pkg::BOOT_CFG_ADDR; // RQ19
    assign hit_osc_trim = bus_addr == nvm_pkg::OSC_TRIM_ADDR; // RQ19
    assign hit_flags = bus_addr == nvm_pkg::FLAGS_ADDR;

    // Accesses are honoured only after the power-up fetch
    assign booted = boot_state == nvm_pkg::BOOT_RUN;
    assign boot_done = booted;

    // Content reads are refused in programming mode once readout is locked
    assign read_locked = program_mode && stored_cfg[nvm_pkg::READOUT_LOCK_BIT]; // RQ13

    // SRAM is freely writable by the program
    assign sram_write = booted && bus_wr && in_sram; // RQ2

    // Data EEPROM: one write per cycle of the timer, upper block lockable
    assign dee_write = booted && bus_wr && in_dee && !ee_busy
        && !(in_dee_upper && active_cfg[nvm_pkg::UPPER_LOCK_BIT]); // RQ2 RQ18

    // Code EEPROM: writes only in program mode with the write lock clear
    assign code_write = booted && code_wr && program_mode
        && !stored_cfg[nvm_pkg::CODE_WRITE_LOCK_BIT]; // RQ3 RQ4

    // Initialization bytes are visible only in programming mode
    assign init_access = booted && program_mode; // RQ11

    // SRAM array hookup
    assign sram_port.we = sram_write;
    assign sram_port.addr = bus_addr[nvm_pkg::DATA_AW-1:0];
    assign sram_port.wdata = bus_wdata;

    // Data EEPROM array hookup
    assign dee_port.we = dee_write;
    assign dee_port.addr = bus_addr[nvm_pkg::DATA_AW-1:0];
    assign dee_port.wdata = bus_wdata;

    // Code EEPROM array hookup
    assign code_port.we = code_write;
    assign code_port.addr = code_addr;
    assign code_port.wdata = code_wdata;

    // Storage arrays of the documented sizes
    byte_array #(
        .DEPTH(nvm_pkg::SRAM_BYTES),
        .AW(nvm_pkg::DATA_AW)
    ) u_sram ( // RQ1
        .core_clk(core_clk),
        .port(sram_port)
    );

    byte_array #(
        .DEPTH(nvm_pkg::DEE_BYTES),
        .AW(nvm_pkg::DATA_AW)
    ) u_data_eeprom ( // RQ1
        .core_clk(core_clk),
        .port(dee_port)
    );

    byte_array #(
        .DEPTH(nvm_pkg::CODE_BYTES),
        .AW(nvm_pkg::CODE_AW)
    ) u_code_eeprom ( // RQ1
        .core_clk(core_clk),
        .port(code_port)
    );

    // Write cycle timer; busy from the edge that accepts a write
    ee_write_timer #(
        .CYCLES(EE_WRITE_CYCLES[nvm_pkg::TIMER_W-1:0])
    ) u_ee_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(dee_write),
        .busy(ee_busy)
    );

    // Ready flag is the inverse of busy; it returns when the timer expires
    assign ee_ready = !ee_busy; // RQ6 RQ7

    // Power-up fetch sequence
    always_comb begin
        next_boot_state = boot_state;
        case (boot_state)
            nvm_pkg::BOOT_FETCH_CFG: begin
                next_boot_state = nvm_pkg::BOOT_FETCH_TRIM;
            end
            nvm_pkg::BOOT_FETCH_TRIM: begin
                next_boot_state = nvm_pkg::BOOT_RUN;
            end
            nvm_pkg::BOOT_RUN: begin
                next_boot_state = nvm_pkg::BOOT_RUN;
            end
            default: begin
                next_boot_state = nvm_pkg::BOOT_FETCH_CFG;
            end
        endcase
    end

    // Fetch state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            boot_state <= nvm_pkg::BOOT_FETCH_CFG;
        end else begin
            boot_state <= next_boot_state;
        end
    end

    // Active configuration copied from the stored bytes during the fetch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_cfg <= nvm_pkg::ZERO_BYTE;
            active_trim <= nvm_pkg::ZERO_BYTE;
        end else begin
            if (boot_state == nvm_pkg::BOOT_FETCH_CFG) begin
                active_cfg <= stored_cfg; // RQ9
            end
            if (boot_state == nvm_pkg::BOOT_FETCH_TRIM) begin
                active_trim <= stored_trim; // RQ9 RQ10
            end
        end
    end

    // Stored boot byte; nonvolatile, so rst keeps it and the readout lock survives
    always_ff @(posedge core_clk) begin
        if (init_access && bus_wr && hit_boot_cfg) begin // RQ11
            stored_cfg <= bus_wdata | (stored_cfg & nvm_pkg::READOUT_LOCK_MASK); // RQ13
        end
    end

    // Stored trim byte; nonvolatile like the boot byte, rst leaves it as programmed
    always_ff @(posedge core_clk) begin
        if (init_access && bus_wr && hit_osc_trim) begin // RQ11
            stored_trim <= bus_wdata;
        end
    end

    // Data space read data, present only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_rdata <= nvm_pkg::ZERO_BYTE;
        end else if (bus_rd && booted) begin
            if (in_sram) begin
                bus_rdata <= read_locked ? nvm_pkg::ZERO_BYTE : sram_port.rdata; // RQ2 RQ13
            end else if (in_dee) begin
                bus_rdata <= read_locked ? nvm_pkg::ZERO_BYTE : dee_port.rdata; // RQ2 RQ13
            end else if (hit_boot_cfg && init_access) begin
                bus_rdata <= stored_cfg; // RQ11
            end else if (hit_osc_trim && init_access) begin
                bus_rdata <= stored_trim; // RQ11
            end else if (hit_flags) begin
                bus_rdata <= nvm_pkg::ZERO_BYTE;
                bus_rdata[nvm_pkg::READY_BIT] <= ee_ready; // RQ6
            end else begin
                bus_rdata <= nvm_pkg::ZERO_BYTE;
            end
        end else begin
            bus_rdata <= nvm_pkg::ZERO_BYTE;
        end
    end

    // Program space read data, refused under readout lock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            code_rdata <= nvm_pkg::ZERO_BYTE;
        end else if (code_rd && booted && !read_locked) begin // RQ2 RQ13
            code_rdata <= code_port.rdata;
        end else begin
            code_rdata <= nvm_pkg::ZERO_BYTE;
        end
    end

    // Peripheral enables and clock selection from the fetched boot byte
    assign low_supply_detect_enable = active_cfg[nvm_pkg::LOW_SUPPLY_BIT]; // RQ14
    assign brownout_reset_enable = active_cfg[nvm_pkg::BROWNOUT_BIT]; // RQ15
    assign watchdog_circuit_enable = active_cfg[nvm_pkg::WATCHDOG_BIT]; // RQ16
    assign clock_source_select = {active_cfg[nvm_pkg::CLK_SEL1_BIT],
        active_cfg[nvm_pkg::CLK_SEL0_BIT]}; // RQ17
    assign osc_trim = active_trim; // RQ10

    // Normal mode writes never reach the code array
    a_code_normal_block: assert property ( // RQ3
        @(posedge core_clk) disable iff (rst)
        (code_wr && !program_mode) |-> !code_port.we
    ) else $error("code write passed in normal mode");

    // Locked code array stays closed in program mode
    a_code_lock_block: assert property ( // RQ4
        @(posedge core_clk) disable iff (rst)
        (code_wr && booted && program_mode) |->
            (code_port.we == !stored_cfg[nvm_pkg::CODE_WRITE_LOCK_BIT])
    ) else $error("code write lock not honoured");

    // Accepted EEPROM write drops ready for several cycles
    a_ready_drops: assert property ( // RQ6
        @(posedge core_clk) disable iff (rst)
        dee_port.we |=> !ee_ready [*2]
    ) else $error("ready did not fall after an EEPROM write");

    // Ready returns only at the end of a busy period
    a_ready_returns: assert property ( // RQ7
        @(posedge core_clk) disable iff (rst)
        $rose(ee_ready) |-> $past(ee_busy) && !$past(dee_port.we)
    ) else $error("ready rose without a completed write");

    // No second EEPROM write while busy
    a_busy_refuses: assert property ( // RQ6
        @(posedge core_clk) disable iff (rst)
        !ee_ready |-> !dee_port.we
    ) else $error("EEPROM written while busy");

    // Upper EEPROM block is protected by its lock
    a_upper_lock: assert property ( // RQ18
        @(posedge core_clk) disable iff (rst)
        (bus_wr && in_dee_upper && active_cfg[nvm_pkg::UPPER_LOCK_BIT]) |-> !dee_port.we
    ) else $error("upper EEPROM block written while locked");

    // Locked readout returns zero for memory contents
    a_readout_zero: assert property ( // RQ13
        @(posedge core_clk) disable iff (rst)
        (bus_rd && read_locked && (in_sram || in_dee)) |=> bus_rdata == nvm_pkg::ZERO_BYTE
    ) else $error("memory contents read under readout lock");

    // Readout lock never clears once set
    a_lock_sticky: assert property ( // RQ13
        @(posedge core_clk) disable iff (rst)
        stored_cfg[nvm_pkg::READOUT_LOCK_BIT] |=> stored_cfg[nvm_pkg::READOUT_LOCK_BIT]
    ) else $error("readout lock cleared");

    // Initialization bytes ignore normal mode writes
    a_init_normal: assert property ( // RQ11
        @(posedge core_clk) disable iff (rst)
        (bus_wr && !program_mode) |=> $stable(stored_cfg) && $stable(stored_trim)
    ) else $error("initialization byte changed in normal mode");

    // Fetch completes two edges after reset with both bytes copied
    a_boot_fetch: assert property ( // RQ9
        @(posedge core_clk) disable iff (rst)
        $rose(booted) |-> active_cfg == stored_cfg && active_trim == stored_trim
            && $past(boot_state, 1) == nvm_pkg::BOOT_FETCH_TRIM
    ) else $error("power-up fetch did not copy the stored bytes");

    // Ready flag reads back through the core flags register
    a_flags_read: assert property ( // RQ6
        @(posedge core_clk) disable iff (rst)
        (bus_rd && booted && hit_flags) |=>
            bus_rdata[nvm_pkg::READY_BIT] == $past(ee_ready)
    ) else $error("flags register does not show ready");

    // Fetched enables follow the stored boot byte
    a_enables_fetched: assert property ( // RQ14 RQ15 RQ16
        @(posedge core_clk) disable iff (rst)
        $rose(booted) |-> low_supply_detect_enable == stored_cfg[nvm_pkg::LOW_SUPPLY_BIT]
            && brownout_reset_enable == stored_cfg[nvm_pkg::BROWNOUT_BIT]
            && watchdog_circuit_enable == stored_cfg[nvm_pkg::WATCHDOG_BIT]
    ) else $error("peripheral enables differ from the boot byte");

    // Clock selection bits cross over when fetched
    a_clock_select: assert property ( // RQ17
        @(posedge core_clk) disable iff (rst)
        $rose(booted) |-> clock_source_select
            == {stored_cfg[nvm_pkg::CLK_SEL1_BIT], stored_cfg[nvm_pkg::CLK_SEL0_BIT]}
    ) else $error("clock selection differs from the boot byte");

    // Writes above the data EEPROM never land in an array
    a_map_unmapped: assert property ( // RQ20
        @(posedge core_clk) disable iff (rst)
        (bus_wr && bus_addr > nvm_pkg::DEE_LAST) |-> !sram_port.we && !dee_port.we
    ) else $error("write outside the memory map reached an array");

    // Locked readout returns zero for code contents
    a_code_readout: assert property ( // RQ13
        @(posedge core_clk) disable iff (rst)
        (code_rd && read_locked) |=> code_rdata == nvm_pkg::ZERO_BYTE
    ) else $error("code contents read under readout lock");
endmodule : nvm_access_top

// ### testbench/core_model.sv
// Core-side model issuing load and store cycles to the access block
module core_model (
    // Clock
    input wire logic core_clk,
    // Data space port
    output logic [7:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [7:0] bus_rdata,
    // Program space port
    output logic [9:0] code_addr,
    output logic [7:0] code_wdata,
    output logic code_wr,
    output logic code_rd,
    input wire logic [7:0] code_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        code_addr = 10'h000;
        code_wdata = 8'h00;
        code_wr = 1'b0;
        code_rd = 1'b0;
    end

    // Load: data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        #1;
        d = bus_rdata;
    endtask : rd

    // Store: one strobe cycle, then unqualified lines are scrambled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask : wr

    // Data EEPROM store only after the ready flag reads set
    task automatic ee_wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] f;
        int n;
        f = 8'h00;
        for (n = 0; n < 40 && f[nvm_pkg::READY_BIT] !== 1'b1; n++) begin
            rd(nvm_pkg::FLAGS_ADDR, f);
        end
        ok = (f[nvm_pkg::READY_BIT] === 1'b1);
        if (ok) begin
            wr(a, d);
        end
    endtask : ee_wr

    // Program space load
    task automatic crd(input logic [9:0] a, output logic [7:0] d);
        @(posedge core_clk);
        code_rd <= 1'b1;
        code_addr <= a;
        @(posedge core_clk);
        code_rd <= 1'b0;
        code_addr <= ~a;
        #1;
        d = code_rdata;
    endtask : crd

    // Program space store attempt
    task automatic cwr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        code_wr <= 1'b1;
        code_addr <= a;
        code_wdata <= d;
        @(posedge core_clk);
        code_wr <= 1'b0;
        code_addr <= ~a;
        code_wdata <= ~d;
    endtask : cwr
endmodule : core_model

// ### testbench/testbench.sv
// Self-checking bench for the nonvolatile access block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EE_CYC = 8;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic program_mode = 1'b0;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, code_wdata, code_rdata, osc_trim, d;
    logic [9:0] code_addr;
    logic bus_wr, bus_rd, code_wr, code_rd, ok;
    logic low_supply_detect_enable, brownout_reset_enable, watchdog_circuit_enable;
    logic [1:0] clock_source_select;
    logic ee_ready, boot_done;
    int bad_count = 0;
    int n_checks = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    core_model i_core (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .code_addr(code_addr),
        .code_wdata(code_wdata), .code_wr(code_wr), .code_rd(code_rd),
        .code_rdata(code_rdata));

    nvm_access_top #(.EE_WRITE_CYCLES(EE_CYC)) i_dut (.core_clk(core_clk), .rst(rst),
        .program_mode(program_mode), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .code_addr(code_addr),
        .code_wdata(code_wdata), .code_wr(code_wr), .code_rd(code_rd),
        .code_rdata(code_rdata), .low_supply_detect_enable(low_supply_detect_enable),
        .brownout_reset_enable(brownout_reset_enable),
        .watchdog_circuit_enable(watchdog_circuit_enable),
        .clock_source_select(clock_source_select), .osc_trim(osc_trim),
        .ee_ready(ee_ready), .boot_done(boot_done));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // Bounded wait for the ready flag, returns cycles waited
    task automatic wait_ready(output int n);
        for (n = 0; n < 40 && ee_ready !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 40) begin
            chk(8'h00, 8'h01, "ready timeout");
            test_done();
        end
    endtask : wait_ready

    // Boot outputs and flags after power-up
    task automatic t_power_up;
        chk({3'b000, low_supply_detect_enable, brownout_reset_enable,
             watchdog_circuit_enable, clock_source_select}, 8'h00, "cfg");
        chk(osc_trim, nvm_pkg::OSC_TRIM_DEFAULT, "trim");
        i_core.rd(nvm_pkg::FLAGS_ADDR, d);
        chk(d, 8'h01, "flags idle");
    endtask : t_power_up

    // SRAM edges of the map
    task automatic t_sram;
        i_core.wr(8'h00, 8'h5a);
        i_core.wr(8'h3f, 8'ha5);
        i_core.rd(8'h00, d);
        chk(d, 8'h5a, "sram lo");
        i_core.rd(8'h3f, d);
        chk(d, 8'ha5, "sram hi");
    endtask : t_sram

    // Data EEPROM store, busy window, read back at both ends
    task automatic t_data_ee;
        int n;
        i_core.ee_wr(8'h40, 8'h3c, ok);
        #1;
        chk({7'h00, ok}, 8'h01, "poll ready");
        chk({7'h00, ee_ready}, 8'h00, "busy");
        wait_ready(n);
        chk({7'h00, n == EE_CYC}, 8'h01, "busy len");
        i_core.rd(8'h40, d);
        chk(d, 8'h3c, "ee lo");
        i_core.ee_wr(8'h7f, 8'hc3, ok);
        i_core.rd(nvm_pkg::FLAGS_ADDR, d);
        chk(d, 8'h00, "flags busy");
        wait_ready(n);
        i_core.rd(8'h7f, d);
        chk(d, 8'hc3, "ee hi");
    endtask : t_data_ee

    // Code EEPROM writable in program mode only
    task automatic t_code;
        @(posedge core_clk) program_mode <= 1'b1;
        i_core.cwr(10'h000, 8'h22);
        i_core.cwr(10'h3ff, 8'h33);
        i_core.crd(10'h3ff, d);
        chk(d, 8'h33, "code top");
        @(posedge core_clk) program_mode <= 1'b0;
        i_core.cwr(10'h000, 8'h44);
        i_core.crd(10'h000, d);
        chk(d, 8'h22, "code normal wr");
    endtask : t_code

    // Initialization bytes, write lock, sticky readout lock
    task automatic t_init;
        i_core.wr(nvm_pkg::BOOT_CFG_ADDR, 8'hff);
        i_core.rd(nvm_pkg::BOOT_CFG_ADDR, d);
        chk(d, 8'h00, "init normal");
        @(posedge core_clk) program_mode <= 1'b1;
        i_core.rd(nvm_pkg::OSC_TRIM_ADDR, d);
        chk(d, nvm_pkg::OSC_TRIM_DEFAULT, "trim rd");
        i_core.cwr(10'h005, 8'h66);
        i_core.wr(nvm_pkg::BOOT_CFG_ADDR, 8'hfe);
        i_core.rd(nvm_pkg::BOOT_CFG_ADDR, d);
        chk(d, 8'hfe, "init rw");
        i_core.cwr(10'h005, 8'h77);
        i_core.crd(10'h005, d);
        chk(d, 8'h66, "code locked");
        chk({3'b000, low_supply_detect_enable, brownout_reset_enable,
             watchdog_circuit_enable, clock_source_select}, 8'h00, "cfg held");
        i_core.wr(nvm_pkg::BOOT_CFG_ADDR, 8'h01);
        i_core.rd(8'h00, d);
        chk(d, 8'h00, "readout sram");
        i_core.crd(10'h005, d);
        chk(d, 8'h00, "readout code");
        i_core.wr(nvm_pkg::BOOT_CFG_ADDR, 8'h00);
        i_core.rd(nvm_pkg::BOOT_CFG_ADDR, d);
        chk(d, 8'h01, "lock sticky");
        @(posedge core_clk) program_mode <= 1'b0;
        i_core.rd(8'h00, d);
        chk(d, 8'h5a, "normal read");
    endtask : t_init

    // Unmapped place and read-only flags
    task automatic t_misc;
        i_core.wr(8'h90, 8'h77);
        i_core.rd(8'h90, d);
        chk(d, 8'h00, "unmapped");
        i_core.wr(nvm_pkg::FLAGS_ADDR, 8'h00);
        i_core.rd(nvm_pkg::FLAGS_ADDR, d);
        chk(d, 8'h01, "flags ro");
    endtask : t_misc

    // Mid-run reset fetches a programmed boot byte; lock and data survive it
    task automatic t_reboot;
        int n;
        @(posedge core_clk) program_mode <= 1'b1;
        i_core.wr(nvm_pkg::BOOT_CFG_ADDR, 8'h7c);
        @(posedge core_clk);
        rst <= 1'b1;
        program_mode <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (n = 0; n < 10 && boot_done !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk({7'h00, boot_done}, 8'h01, "reboot");
        chk({3'b000, low_supply_detect_enable, brownout_reset_enable,
             watchdog_circuit_enable, clock_source_select}, 8'h1e, "cfg2");
        chk(osc_trim, nvm_pkg::OSC_TRIM_DEFAULT, "trim kept");
        i_core.ee_wr(8'h7f, 8'h11, ok);
        i_core.rd(8'h7f, d);
        chk(d, 8'hc3, "upper locked");
        @(posedge core_clk) program_mode <= 1'b1;
        i_core.rd(nvm_pkg::BOOT_CFG_ADDR, d);
        chk(d, 8'h7d, "lock after reset");
        @(posedge core_clk) program_mode <= 1'b0;
    endtask : t_reboot

    // Main sequence
    initial begin
        int n;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (n = 0; n < 10 && boot_done !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk({7'h00, boot_done}, 8'h01, "boot");
        t_power_up();
        t_sram();
        t_data_ee();
        t_code();
        t_init();
        t_misc();
        t_reboot();
        test_done();
    end
endmodule : testbench
